// file: smbid_bank.sv
//Contract
// - Host-written five-bit count sets read length
// - Count resets to 8, nine bytes returned
// - Count bits 7 to 5 read zero
// - Interface works only while reference clock runs
// - Block read sends count byte before data
module smbid_bank
  import smbid_pkg::*;
#(
  parameter logic [7:0] DEV_ID = SMBID_DEV_ID_DEFAULT
) (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic ref_clk_running_i,
  input wire logic wr_stb_i,
  input wire logic [7:0] wr_index_i,
  input wire logic [7:0] wr_data_i,
  input wire logic rd_start_i,
  input wire logic [7:0] rd_index_i,
  input wire logic rd_next_i,
  input wire logic rd_stop_i,
  input wire logic [7:0] ext_rd_data_i,
  output logic [7:0] ext_rd_index_o,
  output logic [7:0] rd_data_o,
  output logic rd_valid_o,
  output logic rd_last_o,
  output logic [SMBID_CNT_W-1:0] count_o
);
  typedef struct packed {
    smbid_state_t st;
    logic [7:0] ptr;
    logic [SMBID_LEFT_W-1:0] left;
    logic [7:0] rd_data;
    logic rd_valid;
    logic rd_last;
    logic [SMBID_CNT_W-1:0] count;
  } smbid_bank_st_t;

  smbid_bank_st_t s_r;
  smbid_bank_st_t s_nxt;
  smbid_reg_if rif ();
  logic own_idx;
  logic [7:0] byte_sel;
  logic take_start;
  logic take_next;

  smbid_regs #(
    .DEV_ID(DEV_ID)
  ) u_regs (
    .core_clk_i(core_clk_i),
    .rst_n_i(rst_n_i),
    .bus(rif)
  );

  // ==================================================
  // Register access
  // Per-byte writes; the upstream engine walks the block-write index
  assign rif.wr_en = wr_stb_i && ref_clk_running_i;
  assign rif.wr_idx = wr_index_i;
  assign rif.wr_data = wr_data_i;
  assign rif.rd_idx = s_r.ptr;

  // Bytes outside this tail come from the rest of the bank
  assign own_idx = s_r.ptr >= SMBID_IDX_DEVICE_IDENTIFICATION &&
                   s_r.ptr <= SMBID_IDX_RSVD;
  assign byte_sel = own_idx ? rif.rd_data : ext_rd_data_i;

  // ==================================================
  // Block-read sequencer
  always_comb begin
    s_nxt = s_r;
    s_nxt.rd_valid = 1'b0;
    s_nxt.rd_last = 1'b0;
    s_nxt.count = rif.count;
    case (s_r.st)
      SMBID_IDLE: begin
        if (ref_clk_running_i && rd_start_i) begin
          s_nxt.st = SMBID_DATA;
          s_nxt.ptr = rd_index_i;
          // Count X returns X+1 bytes, so a count of 8 gives 0..8
          s_nxt.left = {1'b0, rif.count} + SMBID_LEFT_ONE;
          s_nxt.rd_data = {SMBID_CNT_RSVD_BITS, rif.count};
          s_nxt.rd_valid = 1'b1;
        end
      end
      SMBID_DATA: begin
        if (!ref_clk_running_i || rd_stop_i) begin
          s_nxt.st = SMBID_IDLE;
        end else if (rd_next_i) begin
          s_nxt.rd_data = byte_sel;
          s_nxt.rd_valid = 1'b1;
          s_nxt.ptr = s_r.ptr + SMBID_IDX_STEP;
          s_nxt.left = s_r.left - SMBID_LEFT_ONE;
          if (s_r.left == SMBID_LEFT_ONE) begin
            s_nxt.rd_last = 1'b1;
            s_nxt.st = SMBID_IDLE;
          end
        end
      end
      default: begin
        s_nxt.st = SMBID_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      s_r.st <= SMBID_IDLE;
      s_r.ptr <= 8'h00;
      s_r.left <= 6'h00;
      s_r.rd_data <= 8'h00;
      s_r.rd_valid <= 1'b0;
      s_r.rd_last <= 1'b0;
      s_r.count <= SMBID_CNT_RESET;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign ext_rd_index_o = s_r.ptr;
  assign rd_data_o = s_r.rd_data;
  assign rd_valid_o = s_r.rd_valid;
  assign rd_last_o = s_r.rd_last;
  assign count_o = s_r.count;

  // ==================================================
  // Check helpers
  // Qualified strobes, as the sequencer acts on them
  assign take_start = s_r.st == SMBID_IDLE && ref_clk_running_i &&
                      rd_start_i;
  assign take_next = s_r.st == SMBID_DATA && ref_clk_running_i &&
                     !rd_stop_i && rd_next_i;

  // ==================================================
  // Checks
  a_stopped_clk_idle: assert property (
    @(posedge core_clk_i) disable iff (!rst_n_i)
    !ref_clk_running_i |=> s_r.st == SMBID_IDLE && !rd_last_o)
    else $error("sequencer active with reference clock stopped");
  a_count_byte_first: assert property (
    @(posedge core_clk_i) disable iff (!rst_n_i)
    s_r.st == SMBID_IDLE && ref_clk_running_i && rd_start_i
    |=> rd_valid_o && rd_data_o == {SMBID_CNT_RSVD_BITS, $past(rif.count)})
    else $error("count byte not sent first");
  a_default_nine: assert property (
    @(posedge core_clk_i) disable iff (!rst_n_i)
    s_r.st == SMBID_IDLE && ref_clk_running_i && rd_start_i &&
    rif.count == SMBID_CNT_RESET |=> s_r.left == 6'h09)
    else $error("default read length not nine");
  a_last_ends_read: assert property (
    @(posedge core_clk_i) disable iff (!rst_n_i)
    rd_last_o |-> rd_valid_o && s_r.st == SMBID_IDLE && s_r.left == 6'h00)
    else $error("last byte flagged early");

  // ==================================================
  // Sequencer stepping and count output lag
  a_start_loads_ptr: assert property (
    @(posedge core_clk_i) disable iff (!rst_n_i)
    take_start |=> ext_rd_index_o == $past(rd_index_i))
    else $error("read start index not loaded");

  a_next_steps_ptr: assert property (
    @(posedge core_clk_i) disable iff (!rst_n_i)
    take_next |=> ext_rd_index_o == $past(ext_rd_index_o) + SMBID_IDX_STEP)
    else $error("read index did not step");

  a_left_counts_down: assert property (
    @(posedge core_clk_i) disable iff (!rst_n_i)
    take_next |=> s_r.left == $past(s_r.left) - SMBID_LEFT_ONE)
    else $error("remaining byte count did not step");

  a_last_at_end: assert property (
    @(posedge core_clk_i) disable iff (!rst_n_i)
    take_next && s_r.left == SMBID_LEFT_ONE |=> rd_last_o)
    else $error("final byte not flagged");

  a_no_early_last: assert property (
    @(posedge core_clk_i) disable iff (!rst_n_i)
    take_next && s_r.left != SMBID_LEFT_ONE
    |=> !rd_last_o && s_r.st == SMBID_DATA)
    else $error("read ended before its count");

  a_count_out_lag: assert property (
    @(posedge core_clk_i) disable iff (!rst_n_i)
    $past(rst_n_i) |-> count_o == $past(rif.count))
    else $error("count output does not follow register");

  // ==================================================
  // Byte routing
  a_id_byte_out: assert property (
    @(posedge core_clk_i) disable iff (!rst_n_i)
    take_next && s_r.ptr == SMBID_IDX_DEVICE_IDENTIFICATION |=> rd_data_o == DEV_ID)
    else $error("id byte not sent");

  a_count_byte_out: assert property (
    @(posedge core_clk_i) disable iff (!rst_n_i)
    take_next && s_r.ptr == SMBID_IDX_COUNT
    |=> rd_data_o == {SMBID_CNT_RSVD_BITS, $past(rif.count)})
    else $error("count byte read back wrong");

  a_rsvd_byte_out: assert property (
    @(posedge core_clk_i) disable iff (!rst_n_i)
    take_next && s_r.ptr == SMBID_IDX_RSVD |=> rd_data_o == SMBID_RSVD_VALUE)
    else $error("reserved byte sent nonzero");

  a_ext_byte_out: assert property (
    @(posedge core_clk_i) disable iff (!rst_n_i)
    take_next && !own_idx |=> rd_data_o == $past(ext_rd_data_i))
    else $error("outside byte not passed through");

  // ==================================================
  // Refusals and aborts
  a_valid_has_cause: assert property (
    @(posedge core_clk_i) disable iff (!rst_n_i)
    rd_valid_o |-> $past(ref_clk_running_i) &&
    ($past(rd_start_i) || $past(rd_next_i)))
    else $error("byte sent with no request");

  a_idle_no_byte: assert property (
    @(posedge core_clk_i) disable iff (!rst_n_i)
    s_r.st == SMBID_IDLE && !take_start |=> !rd_valid_o)
    else $error("byte sent without a read");

  a_busy_start_ignored: assert property (
    @(posedge core_clk_i) disable iff (!rst_n_i)
    s_r.st == SMBID_DATA && rd_start_i && !rd_next_i
    |=> !rd_valid_o)
    else $error("start accepted during a read");

  a_stop_ends_read: assert property (
    @(posedge core_clk_i) disable iff (!rst_n_i)
    s_r.st == SMBID_DATA && rd_stop_i
    |=> s_r.st == SMBID_IDLE && !rd_valid_o)
    else $error("stop did not end the read");

  a_stopped_no_write: assert property (
    @(posedge core_clk_i) disable iff (!rst_n_i)
    !ref_clk_running_i |-> !rif.wr_en)
    else $error("write taken with reference clock stopped");

  a_stopped_no_start: assert property (
    @(posedge core_clk_i) disable iff (!rst_n_i)
    s_r.st == SMBID_IDLE && !ref_clk_running_i |=> !rd_valid_o)
    else $error("read started with reference clock stopped");
endmodule

// file: smbid_host.sv
module smbid_host (
  input wire logic clk_i,
  input wire logic vld_i,
  input wire logic last_i,
  input wire logic [7:0] dat_i,
  output logic wr_o,
  output logic [7:0] widx_o,
  output logic [7:0] wdat_o,
  output logic start_o,
  output logic [7:0] ridx_o,
  output logic next_o,
  output logic stop_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========
  // Host side
  initial {wr_o, widx_o, wdat_o, start_o, ridx_o, next_o, stop_o} = '0;
  // One data byte per strobe; wr_block steps the index
  task automatic wr(input logic [7:0] i, d);
    @(posedge clk_i);
    wr_o <= 1'b1;
    widx_o <= i;
    wdat_o <= d;
    @(posedge clk_i);
    wr_o <= 1'b0;
  endtask
  // Random ack delay so both fast and slow pacing occur
  task automatic rd(input logic [7:0] i, input int n, ref logic [8:0] q[$]);
    int t;
    @(posedge clk_i);
    start_o <= 1'b1;
    ridx_o <= i;
    @(posedge clk_i);
    start_o <= 1'b0;
    for (int k = 0; k < n; k++) begin
      t = 0;
      do begin
        @(posedge clk_i);
        t++;
      end while (vld_i !== 1'b1 && t < 12);
      if (vld_i !== 1'b1) return;
      q.push_back({last_i, dat_i});
      if (k == n - 1) return;
      repeat ($urandom_range(1, 0)) @(posedge clk_i);
      next_o <= 1'b1;
      @(posedge clk_i);
      next_o <= 1'b0;
    end
  endtask
  // Block write: the index steps once per data byte
  task automatic wr_block(input logic [7:0] i, input logic [7:0] b[$]);
    foreach (b[k]) begin
      wr(8'(i + k), b[k]);
    end
  endtask
  // Host NACK and stop end a read early
  task automatic stop_read;
    @(posedge clk_i);
    stop_o <= 1'b1;
    @(posedge clk_i);
    stop_o <= 1'b0;
  endtask
endmodule

// file: smbid_pkg.sv
package smbid_pkg;
  // ==================================================
  // Byte indices of this tail of the bank
  localparam logic [7:0] SMBID_IDX_DEVICE_IDENTIFICATION = 8'h06;
  localparam logic [7:0] SMBID_IDX_COUNT = 8'h07;
  localparam logic [7:0] SMBID_IDX_RSVD = 8'h08;
  // ==================================================
  // Field layout and reset values
  localparam int SMBID_CNT_W = 5;
  localparam int SMBID_LEFT_W = 6;
  localparam logic [4:0] SMBID_CNT_RESET = 5'h08;
  localparam logic [2:0] SMBID_CNT_RSVD_BITS = 3'h0;
  localparam logic [7:0] SMBID_RSVD_VALUE = 8'h00;
  // Arbitrary identification value, not tied to any real part
  localparam logic [7:0] SMBID_DEV_ID_DEFAULT = 8'h5A;
  localparam logic [5:0] SMBID_LEFT_ONE = 6'h01;
  localparam logic [7:0] SMBID_IDX_STEP = 8'h01;

  typedef enum logic {SMBID_IDLE, SMBID_DATA} smbid_state_t;
endpackage

// file: smbid_reg_if.sv
interface smbid_reg_if;
  import smbid_pkg::*;
  logic wr_en;
  logic [7:0] wr_idx;
  logic [7:0] wr_data;
  logic [7:0] rd_idx;
  logic [7:0] rd_data;
  logic [SMBID_CNT_W-1:0] count;

  modport regs (
    input wr_en, wr_idx, wr_data, rd_idx,
    output rd_data, count
  );
  modport ctrl (
    output wr_en, wr_idx, wr_data, rd_idx,
    input rd_data, count
  );
endinterface

// file: smbid_regs.sv
module smbid_regs
  import smbid_pkg::*;
#(
  parameter logic [7:0] DEV_ID = SMBID_DEV_ID_DEFAULT
) (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  smbid_reg_if.regs bus
);
  typedef struct packed {
    logic [SMBID_CNT_W-1:0] count;
  } smbid_regs_st_t;

  smbid_regs_st_t st_r;
  smbid_regs_st_t st_nxt;

  always_comb begin
    st_nxt = st_r;
    // ID and reserved byte: acknowledged upstream, value dropped
    if (bus.wr_en && bus.wr_idx == SMBID_IDX_COUNT) begin
      st_nxt.count = bus.wr_data[SMBID_CNT_W-1:0];
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      st_r.count <= SMBID_CNT_RESET;
    end else begin
      st_r <= st_nxt;
    end
  end

  always_comb begin
    case (bus.rd_idx)
      SMBID_IDX_DEVICE_IDENTIFICATION: bus.rd_data = DEV_ID;
      SMBID_IDX_COUNT: bus.rd_data = {SMBID_CNT_RSVD_BITS, st_r.count};
      SMBID_IDX_RSVD: bus.rd_data = SMBID_RSVD_VALUE;
      default: bus.rd_data = SMBID_RSVD_VALUE;
    endcase
  end

  assign bus.count = st_r.count;

  // ==================================================
  // Checks
  a_id_fixed_value: assert property (
    @(posedge core_clk_i) disable iff (!rst_n_i)
    bus.rd_idx == SMBID_IDX_DEVICE_IDENTIFICATION |-> bus.rd_data == DEV_ID)
    else $error("device_identification byte changed");
  a_count_write_takes: assert property (
    @(posedge core_clk_i) disable iff (!rst_n_i)
    bus.wr_en && bus.wr_idx == SMBID_IDX_COUNT
    |=> bus.count == $past(bus.wr_data[SMBID_CNT_W-1:0]))
    else $error("count write not stored");
  a_count_other_hold: assert property (
    @(posedge core_clk_i) disable iff (!rst_n_i)
    !(bus.wr_en && bus.wr_idx == SMBID_IDX_COUNT) |=> $stable(bus.count))
    else $error("count changed without a write");
  a_count_reset_val: assert property (
    @(posedge core_clk_i)
    !rst_n_i |=> bus.count == SMBID_CNT_RESET)
    else $error("count reset value wrong");
  a_count_top_zero: assert property (
    @(posedge core_clk_i) disable iff (!rst_n_i)
    bus.rd_idx == SMBID_IDX_COUNT |-> bus.rd_data[7:5] == SMBID_CNT_RSVD_BITS)
    else $error("count reserved bits not zero");
  a_rsvd_reads_zero: assert property (
    @(posedge core_clk_i) disable iff (!rst_n_i)
    bus.rd_idx == SMBID_IDX_RSVD |-> bus.rd_data == SMBID_RSVD_VALUE)
    else $error("reserved byte not zero");
endmodule

// file: testbench.sv
module testbench import smbid_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic run = 1'b1;
  logic wr, start, next, stop, vld, last;
  logic [7:0] widx, wdat, ridx, rdat, eidx, d;
  logic [4:0] cnt;
  logic [8:0] q[$];
  int n_fail = 0;
  int checked = 0;
  int cm = 8;
  initial forever #2.5 clk = ~clk;
  smbid_bank smbid_bank_i (.core_clk_i(clk), .rst_n_i(rst_n),
    .ref_clk_running_i(run), .wr_stb_i(wr), .wr_index_i(widx),
    .wr_data_i(wdat), .rd_start_i(start), .rd_index_i(ridx),
    .rd_next_i(next), .rd_stop_i(stop), .ext_rd_data_i(eidx ^ 8'hA5),
    .ext_rd_index_o(eidx), .rd_data_o(rdat), .rd_valid_o(vld),
    .rd_last_o(last), .count_o(cnt));
  smbid_host smbid_host_i (.clk_i(clk), .vld_i(vld), .last_i(last),
    .dat_i(rdat), .wr_o(wr), .widx_o(widx), .wdat_o(wdat),
    .start_o(start), .ridx_o(ridx), .next_o(next), .stop_o(stop));
  // ==========
  // Model and checks
  function automatic logic [7:0] expb(input logic [7:0] i);
    case (i)
      SMBID_IDX_DEVICE_IDENTIFICATION: return SMBID_DEV_ID_DEFAULT;
      SMBID_IDX_COUNT: return {3'h0, 5'(cm)};
      SMBID_IDX_RSVD: return 8'h00;
      default: return i ^ 8'hA5;
    endcase
  endfunction
  task automatic chk(input string s, input logic [8:0] e, g);
    checked++;
    if (g !== e) begin
      n_fail++;
      $display("unexpected %s exp %h got %h", s, e, g);
    end
  endtask
  task automatic rdchk(input logic [7:0] i);
    q.delete();
    smbid_host_i.rd(i, cm + 2, q);
    chk("length", 9'(cm + 2), 9'(q.size()));
    chk("count byte", {4'h0, 5'(cm)}, q[0]);
    for (int k = 1; k < q.size(); k++) begin
      chk("byte", {k == cm + 1, expb(8'(i + k - 1))}, q[k]);
    end
  endtask
  task automatic finish_test;
    $display("checks %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  initial begin
    #100us;
    n_fail++;
    finish_test();
  end
  // ==========
  // Tests
  initial begin
    void'($urandom(24));
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    chk("count_o", 9'h008, {4'h0, cnt});
    rdchk(8'h00);
    $display("test reset done");
    for (int r = 0; r < 4; r++) begin
      smbid_host_i.wr(SMBID_IDX_DEVICE_IDENTIFICATION, 8'($urandom));
      smbid_host_i.wr(SMBID_IDX_RSVD, 8'($urandom));
      d = 8'($urandom);
      smbid_host_i.wr(SMBID_IDX_COUNT, d);
      cm = d[4:0];
      repeat (2) @(posedge clk);
      chk("count_o", {4'h0, d[4:0]}, {4'h0, cnt});
      rdchk(8'($urandom_range(8)));
    end
    $display("test writes done");
    run <= 1'b0;
    smbid_host_i.wr(SMBID_IDX_COUNT, 8'h03);
    q.delete();
    smbid_host_i.rd(8'h06, 1, q);
    chk("stopped read", 9'h000, 9'(q.size()));
    run <= 1'b1;
    rdchk(8'h06);
    $display("test clock stop done");
    d = 8'($urandom);
    smbid_host_i.wr_block(SMBID_IDX_DEVICE_IDENTIFICATION, '{d, 8'h0A, d});
    cm = 10;
    q.delete();
    smbid_host_i.rd(8'h05, 3, q);
    smbid_host_i.stop_read();
    chk("cut length", 9'h003, 9'(q.size()));
    chk("cut count", {4'h0, 5'(cm)}, q[0]);
    for (int k = 1; k < 3; k++) begin
      chk("cut byte", {1'b0, expb(8'(4 + k))}, q[k]);
    end
    rdchk(8'h04);
    q.delete();
    smbid_host_i.rd(8'h00, 2, q);
    run <= 1'b0;
    @(posedge clk);
    run <= 1'b1;
    rdchk(8'h02);
    rst_n <= 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    cm = 8;
    @(posedge clk);
    chk("count_o", 9'h008, {4'h0, cnt});
    rdchk(8'h03);
    $display("test abort and reset done");
    finish_test();
  end
endmodule
